// [verilog/pdb_pkg.sv]
// constants and carrier types for the five-channel pwm duty and blanking block
// assumes a 40 mhz clock and a 32-bit avalon-mm register bus
package pdb_pkg;

  // ---------------------------------------------------------------
  // channels and register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam int NCH = 5;
  localparam logic [7:0] OFF_PDUTY = 8'h00;
  localparam logic [7:0] OFF_SDUTY = 8'h04;
  localparam logic [7:0] OFF_BCTRL = 8'h08;
  localparam logic [7:0] OFF_AUX = 8'h0c;
  localparam logic [7:0] OFF_BDUR = 8'h10;
  localparam logic [7:0] OFF_MODE = 8'h14;
  localparam logic [7:0] OFF_PERIOD = 8'ha0;
  localparam logic [7:0] OFF_STATUS = 8'ha4;
  localparam int CH_SHIFT = 5;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [15:0] DUTY_RST = 16'h0000;
  localparam logic [15:0] BCTRL_RST = 16'h0000;
  localparam logic [15:0] BCTRL_MASK = 16'hfc3f;
  localparam logic [15:0] BDUR_RST = 16'h0000;
  localparam logic [3:0] AUX_RST = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam int B_HR = 15;
  localparam int B_HF = 14;
  localparam int B_LR = 13;
  localparam int B_LF = 12;
  localparam int B_FLT = 11;
  localparam int B_CL = 10;
  localparam int B_BCH = 5;
  localparam int B_BCL = 4;
  localparam int B_BLANK_WHEN_HIGH_SIDE_HIGH = 3;
  localparam int B_BLANK_WHEN_HIGH_SIDE_LOW = 2;
  localparam int B_BLANK_WHEN_LOW_SIDE_HIGH = 1;
  localparam int B_BLANK_WHEN_LOW_SIDE_LOW = 0;

  // ---------------------------------------------------------------
  // duty limits and timing
  // ---------------------------------------------------------------
  localparam logic [15:0] MIN_DUTY = 16'h0008;
  localparam int CLK_NS = 25;
  localparam int EDGE_NS = 40;
  localparam int EDGE_CYC_RAW = EDGE_NS / CLK_NS;
  localparam logic [15:0] EDGE_CNT = 16'(EDGE_CYC_RAW < 1 ? 1 : EDGE_CYC_RAW);

  typedef enum logic [1:0] {
    MODE_INDEP,
    MODE_COMPL,
    MODE_REDUND,
    MODE_PUSHPULL
  } pdb_mode_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] dur;
  } pdb_leb_cfg_t;

  typedef struct packed {
    logic fault;
    logic climit;
  } pdb_prot_t;

endpackage

// [verilog/pdb_blank.sv]
// leading-edge and state blanking of one channel's fault and current-limit
// assumes all inputs are already on clk_in (synchronised or registered)
`timescale 1ns/100ps
module pdb_blank (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input pdb_pkg::pdb_leb_cfg_t cfg_in,
  input wire logic sel_signal_in,
  input wire logic high_in,
  input wire logic low_in,
  input pdb_pkg::pdb_prot_t prot_in,
  output pdb_pkg::pdb_prot_t prot_out,
  output logic active_out
);
  import pdb_pkg::*;

  typedef struct packed {
    logic hi;
    logic lo;
    logic [15:0] cnt;
    pdb_prot_t prot;
  } pdb_blank_state_t;

  pdb_blank_state_t q;
  pdb_blank_state_t d;
  logic start;
  logic leb;
  logic state_blank;

  // ---------------------------------------------------------------
  // edge triggers, counter and masking
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.hi = high_in;
    d.lo = low_in;
    start = 1'b0;
    if (cfg_in.ctrl[B_HR] && high_in && !q.hi) begin
      start = 1'b1;
    end
    if (cfg_in.ctrl[B_HF] && !high_in && q.hi) begin
      start = 1'b1;
    end
    if (cfg_in.ctrl[B_LR] && low_in && !q.lo) begin
      start = 1'b1;
    end
    if (cfg_in.ctrl[B_LF] && !low_in && q.lo) begin
      start = 1'b1;
    end
    // a new edge restarts the window rather than extending it
    if (start) begin
      d.cnt = cfg_in.dur;
    end else if (q.cnt != 16'h0000) begin
      d.cnt = q.cnt - 16'h0001;
    end
    leb = (q.cnt != 16'h0000);
    state_blank = (cfg_in.ctrl[B_BCH] && sel_signal_in)
      || (cfg_in.ctrl[B_BCL] && !sel_signal_in)
      || (cfg_in.ctrl[B_BLANK_WHEN_HIGH_SIDE_HIGH] && high_in)
      || (cfg_in.ctrl[B_BLANK_WHEN_HIGH_SIDE_LOW] && !high_in)
      || (cfg_in.ctrl[B_BLANK_WHEN_LOW_SIDE_HIGH] && low_in)
      || (cfg_in.ctrl[B_BLANK_WHEN_LOW_SIDE_LOW] && !low_in);
    d.prot.fault = prot_in.fault && !(state_blank || (leb && cfg_in.ctrl[B_FLT]));
    d.prot.climit = prot_in.climit && !(state_blank || (leb && cfg_in.ctrl[B_CL]));
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign prot_out = q.prot;
  assign active_out = leb;

endmodule

// [verilog/pdb_top.sv]
// five-channel pwm duty generator with leading-edge and state blanking
// assumes an avalon-mm master on clk_in and asynchronous protection pins
`timescale 1ns/100ps
module pdb_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [pdb_pkg::NCH-1:0] fault_in,
  input wire logic [pdb_pkg::NCH-1:0] current_limit_in,
  input wire logic [15:0] blank_signal_in,
  output logic [pdb_pkg::NCH-1:0] high_side_output_out,
  output logic [pdb_pkg::NCH-1:0] low_side_output_out,
  output logic [pdb_pkg::NCH-1:0] fault_masked_out,
  output logic [pdb_pkg::NCH-1:0] current_limit_masked_out
);
  import pdb_pkg::*;

  typedef struct packed {
    logic [NCH-1:0][15:0] pduty;
    logic [NCH-1:0][15:0] sduty;
    logic [NCH-1:0][15:0] bctrl;
    logic [NCH-1:0][15:0] bdur;
    logic [NCH-1:0][3:0] aux;
    logic [NCH-1:0][1:0] mode;
    logic [15:0] period;
    logic [15:0] cnt;
    logic phase;
    logic [NCH-1:0] hi;
    logic [NCH-1:0] lo;
    logic ack;
    logic [31:0] rdata;
    logic [NCH-1:0] flt_s1;
    logic [NCH-1:0] flt_s2;
    logic [NCH-1:0] cl_s1;
    logic [NCH-1:0] cl_s2;
    logic [15:0] bs_s1;
    logic [15:0] bs_s2;
  } pdb_top_state_t;

  pdb_top_state_t q;
  pdb_top_state_t d;
  logic [NCH-1:0] leb_active;
  pdb_prot_t [NCH-1:0] prot_masked;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // true when the address falls inside one of the channel blocks
  function automatic logic ch_hit(input logic [7:0] a);
    return (int'(a[7:CH_SHIFT]) < NCH);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  // clamps the programmed duty into the range the output stage can form
  function automatic logic [15:0] eff_duty(input logic [15:0] duty, input logic [15:0] per);
    logic [15:0] top;
    logic [15:0] e;
    top = per - MIN_DUTY;
    e = (duty < MIN_DUTY) ? MIN_DUTY : duty;
    if (e > top) begin
      e = top;
    end
    // near either end the step doubles; keeps edge timing of the stage legal
    if ((e < MIN_DUTY + EDGE_CNT) || (e + EDGE_CNT > top)) begin
      e = {e[15:1], 1'b0};
    end
    // a period too short for two minimum pulses gives zero duty; complementary mode then holds the low side on
    if (per < {MIN_DUTY[14:0], 1'b0}) begin
      e = 16'h0000;
    end
    return e;
  endfunction

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [4:0] off;
    int ch;
    logic [15:0] ep;
    logic [15:0] es;
    logic base;
    off = avs_address_in[CH_SHIFT-1:0];
    ch = int'(avs_address_in[7:CH_SHIFT]);
    ep = 16'h0000;
    es = 16'h0000;
    base = 1'b0;
    d = q;

    // synchronisers for pins
    d.flt_s1 = fault_in;
    d.flt_s2 = q.flt_s1;
    d.cl_s1 = current_limit_in;
    d.cl_s2 = q.cl_s1;
    d.bs_s1 = blank_signal_in;
    d.bs_s2 = q.bs_s1;

    // bus: one wait cycle, then the answer
    d.ack = (avs_read_in || avs_write_in) && !q.ack;
    if (avs_read_in && !q.ack) begin
      d.rdata = 32'h0000_0000;
      if (ch_hit(avs_address_in)) begin
        unique case ({3'h0, off})
          OFF_PDUTY: d.rdata[15:0] = q.pduty[ch];
          OFF_SDUTY: d.rdata[15:0] = q.sduty[ch];
          OFF_BCTRL: d.rdata[15:0] = q.bctrl[ch] & BCTRL_MASK;
          OFF_AUX: d.rdata[3:0] = q.aux[ch];
          OFF_BDUR: d.rdata[15:0] = q.bdur[ch];
          OFF_MODE: d.rdata[1:0] = q.mode[ch];
          default: d.rdata = 32'h0000_0000;
        endcase
      end else if (avs_address_in == OFF_PERIOD) begin
        d.rdata[15:0] = q.period;
      end else if (avs_address_in == OFF_STATUS) begin
        d.rdata[14:0] = {leb_active, q.lo, q.hi};
      end
    end
    if (avs_write_in && q.ack) begin
      if (ch_hit(avs_address_in)) begin
        unique case ({3'h0, off})
          OFF_PDUTY: d.pduty[ch] = merge16(q.pduty[ch], avs_writedata_in[15:0],
                                           avs_byteenable_in[1:0]);
          OFF_SDUTY: d.sduty[ch] = merge16(q.sduty[ch], avs_writedata_in[15:0],
                                           avs_byteenable_in[1:0]);
          OFF_BCTRL: d.bctrl[ch] = merge16(q.bctrl[ch], avs_writedata_in[15:0],
                                           avs_byteenable_in[1:0]) & BCTRL_MASK;
          OFF_AUX: begin
            if (avs_byteenable_in[0]) begin
              d.aux[ch] = avs_writedata_in[3:0];
            end
          end
          OFF_BDUR: d.bdur[ch] = merge16(q.bdur[ch], avs_writedata_in[15:0],
                                         avs_byteenable_in[1:0]);
          OFF_MODE: begin
            if (avs_byteenable_in[0]) begin
              d.mode[ch] = avs_writedata_in[1:0];
            end
          end
          default: d.mode = q.mode;
        endcase
      end else if (avs_address_in == OFF_PERIOD) begin
        d.period = merge16(q.period, avs_writedata_in[15:0], avs_byteenable_in[1:0]);
      end
    end

    // shared time base; phase alternates each period for push-pull
    if (q.cnt >= q.period) begin
      d.cnt = 16'h0000;
      d.phase = !q.phase;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end

    // per-channel outputs, registered so they reach the pins glitch-free
    for (int i = 0; i < NCH; i++) begin
      ep = eff_duty(q.pduty[i], q.period);
      es = eff_duty(q.sduty[i], q.period);
      base = (q.cnt < ep);
      unique case (pdb_mode_t'(q.mode[i]))
        MODE_INDEP: begin
          d.hi[i] = base;
          d.lo[i] = (q.cnt < es);
        end
        MODE_COMPL: begin
          d.hi[i] = base;
          d.lo[i] = !base;
        end
        MODE_REDUND: begin
          d.hi[i] = base;
          d.lo[i] = base;
        end
        MODE_PUSHPULL: begin
          d.hi[i] = base && !q.phase;
          d.lo[i] = base && q.phase;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q <= '0;
      q.pduty <= {NCH{DUTY_RST}};
      q.sduty <= {NCH{DUTY_RST}};
      q.bctrl <= {NCH{BCTRL_RST}};
      q.bdur <= {NCH{BDUR_RST}};
      q.aux <= {NCH{AUX_RST}};
      q.period <= PERIOD_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // blanking units
  // ---------------------------------------------------------------
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      pdb_leb_cfg_t cfg;
      pdb_prot_t prot_raw;
      logic sel_sig;
      assign cfg.ctrl = q.bctrl[g];
      assign cfg.dur = q.bdur[g];
      assign prot_raw.fault = q.flt_s2[g];
      assign prot_raw.climit = q.cl_s2[g];
      assign sel_sig = q.bs_s2[q.aux[g]];
      pdb_blank u_blank (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .cfg_in(cfg),
        .sel_signal_in(sel_sig),
        .high_in(q.hi[g]),
        .low_in(q.lo[g]),
        .prot_in(prot_raw),
        .prot_out(prot_masked[g]),
        .active_out(leb_active[g])
      );
      assign fault_masked_out[g] = prot_masked[g].fault;
      assign current_limit_masked_out[g] = prot_masked[g].climit;
    end
  endgenerate

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !q.ack;
  assign avs_readdata_out = q.rdata;
  assign high_side_output_out = q.hi;
  assign low_side_output_out = q.lo;

endmodule

// [testbench/pdb_monitor.sv]
// concurrent checks on the ports of pdb_top, attached by bind
// assumes one clock domain and a master that keeps the avalon rules
`timescale 1ns/100ps
module pdb_monitor (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [pdb_pkg::NCH-1:0] fault_in,
  input wire logic [pdb_pkg::NCH-1:0] current_limit_in,
  input wire logic [pdb_pkg::NCH-1:0] fault_masked_out,
  input wire logic [pdb_pkg::NCH-1:0] current_limit_masked_out
);
  import pdb_pkg::*;
  logic req;
  logic rd_ok;
  assign req = avs_read_in | avs_write_in;
  assign rd_ok = avs_read_in & ~avs_waitrequest_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // --------------------------------
  // bus handshake and read data
  // --------------------------------
  a_one_wait: assert property (avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("wait state longer than one cycle");
  a_new_req_wait: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("no wait state on new request");
  a_idle_no_wait: assert property (!req |-> !avs_waitrequest_out)
    else $error("wait without request");
  a_rdata_hold: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved without read");
  a_upper_zero: assert property (rd_ok |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_ctrl_gap: assert property (rd_ok && avs_address_in < OFF_PERIOD
    && avs_address_in[4:0] == OFF_BCTRL[4:0] |-> avs_readdata_out[9:6] == 4'h0)
    else $error("unused control bits read set");
  a_sel_width: assert property (rd_ok && avs_address_in < OFF_PERIOD
    && avs_address_in[4:0] == OFF_AUX[4:0] |-> avs_readdata_out[15:4] == 12'h000)
    else $error("selector wider than four bits");
  a_hole_zero: assert property (rd_ok && (avs_address_in[7:2] > OFF_STATUS[7:2]
    || (avs_address_in < OFF_PERIOD && avs_address_in[4:2] > 3'h5)) |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  // --------------------------------
  // masking never invents a trip
  // --------------------------------
  a_fault_cause: assert property ((fault_masked_out & ~$past(fault_in, 3)) == 5'h00)
    else $error("masked fault without fault pin");
  a_limit_cause: assert property ((current_limit_masked_out & ~$past(current_limit_in, 3)) == 5'h00)
    else $error("masked limit without limit pin");
endmodule
bind pdb_top pdb_monitor u_mon (.clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .fault_in, .current_limit_in, .fault_masked_out,
  .current_limit_masked_out);

// [testbench/pdb_stage.sv]
// behavioural power stage that the pwm outputs drive
// assumes the bench sets overload to stand for an overcurrent event
`timescale 1ns/100ps
module pdb_stage (
  input wire logic clk_in,
  input wire logic [pdb_pkg::NCH-1:0] overload_in,
  input wire logic [pdb_pkg::NCH-1:0] high_in,
  input wire logic [pdb_pkg::NCH-1:0] low_in,
  output logic [pdb_pkg::NCH-1:0] fault_out,
  output logic [pdb_pkg::NCH-1:0] climit_out
);
  import pdb_pkg::*;
  initial begin
    fault_out = '0;
    climit_out = '0;
  end
  // both legs on is shoot-through, which the stage reports as a fault
  always @(posedge clk_in) begin
    fault_out <= overload_in | (high_in & low_in);
    climit_out <= overload_in;
  end
endmodule

// [testbench/tb.sv]
// self-checking bench for pdb_top with a power stage model
// assumes channel 0 carries the pwm and blanking scenarios
`timescale 1ns/100ps
module tb;
  import pdb_pkg::*;
  localparam int PER = 40;
  localparam int P1 = PER + 1;
  localparam int HI = 10;
  localparam int LO = 20;
  localparam int DUR = 4;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [NCH-1:0] overload = '0;
  logic [NCH-1:0] fault_in, current_limit_in, high_side_output_out, low_side_output_out;
  logic [NCH-1:0] fault_masked_out, current_limit_masked_out;
  logic [15:0] blank_signal_in = 16'h0008;
  logic [31:0] seed = 32'hfdf3a1f7;
  logic [31:0] rd;
  int fails = 0;
  int comparisons = 0;
  int nh, nl, nf, nc;
  int duties[$] = '{2, 9, 10, 31, 39};
  logic [15:0] ctrls[12] = '{16'h8800, 16'h4400, 16'h2800, 16'h1c00, 16'hf000, 16'h0008,
    16'h0004, 16'h0002, 16'h0001, 16'h0020, 16'h0010, 16'h0020};
  logic [3:0] auxs[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 3, 3, 2};

  pdb_top dut (.clk_in, .reset_n_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .fault_in, .current_limit_in,
    .blank_signal_in, .high_side_output_out, .low_side_output_out, .fault_masked_out,
    .current_limit_masked_out);
  pdb_stage u_stage (.clk_in, .overload_in(overload), .high_in(high_side_output_out),
    .low_in(low_side_output_out), .fault_out(fault_in), .climit_out(current_limit_in));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // clamp to the pulse limits, then lose bit 0 next to either limit
  function automatic int eff(input int d);
    int e;
    e = d < 8 ? 8 : (d > PER - 8 ? PER - 8 : d);
    if (e < 8 + int'(EDGE_CNT) || e > PER - 8 - int'(EDGE_CNT)) e = e & ~1;
    return e;
  endfunction
  function automatic int blank_cnt(input logic [15:0] c, input logic s, input logic leb);
    int n;
    n = (c[3] ? HI : 0) + (c[2] ? P1 - HI : 0) + (c[1] ? LO : 0) + (c[0] ? P1 - LO : 0);
    if ((c[5] && s) || (c[4] && !s)) n = P1;
    if (leb) n = n + DUR * (c[15] + c[14] + c[13] + c[12]);
    return n;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int t;
    t = 0;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= {16'h0000, d};
    avs_read_in <= ~w;
    avs_write_in <= w;
    do begin
      @(posedge clk_in);
      t++;
    end while (avs_waitrequest_out !== 1'b0 && t < 20);
    if (t == 20) fails++;
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic meas(input int n);
    nh = 0;
    nl = 0;
    nf = 0;
    nc = 0;
    repeat (100) @(posedge clk_in);
    repeat (n) begin
      @(posedge clk_in);
      nh += (high_side_output_out[0] === 1'b1);
      nl += (low_side_output_out[0] === 1'b1);
      nf += (fault_masked_out[0] === 1'b0);
      nc += (current_limit_masked_out[0] === 1'b0);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_in);
    fails++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int ch = 0; ch < NCH; ch++) begin
      for (int o = 0; o < 6; o++) begin
        bus(1'b0, 8'(ch * 32 + o * 4), 16'h0000);
        chk(rd, 32'h0);
      end
      seed = lfsr(seed);
      bus(1'b1, 8'(ch * 32) + OFF_PDUTY, seed[15:0]);
      bus(1'b1, 8'(ch * 32) + OFF_SDUTY, seed[31:16]);
      bus(1'b0, 8'(ch * 32) + OFF_PDUTY, 16'h0000);
      chk(rd, {16'h0000, seed[15:0]});
      bus(1'b0, 8'(ch * 32) + OFF_SDUTY, 16'h0000);
      chk(rd, {16'h0000, seed[31:16]});
    end
    // upper lane only: the low byte of the last channel must survive
    avs_byteenable_in <= 4'h2;
    bus(1'b1, 8'h80, 16'h0000);
    avs_byteenable_in <= 4'hf;
    bus(1'b0, 8'h80, 16'h0000);
    chk(rd, {24'h000000, seed[7:0]});
    bus(1'b1, OFF_BCTRL, 16'hffff);
    bus(1'b0, OFF_BCTRL, 16'h0000);
    chk(rd, 32'h0000fc3f);
    bus(1'b1, 8'hfc, seed[15:0]);
    bus(1'b0, 8'hfc, 16'h0000);
    chk(rd, 32'h0);
    bus(1'b0, 8'h18, 16'h0000);
    chk(rd, 32'h0);
    bus(1'b1, OFF_BCTRL, 16'h0000);
    bus(1'b1, OFF_PERIOD, 16'(PER));
    bus(1'b0, OFF_PERIOD, 16'h0000);
    chk(rd, PER);
    bus(1'b0, OFF_STATUS, 16'h0000);
    chk(rd >> 15, 32'h0);
    bus(1'b1, OFF_SDUTY, 16'(LO));
    bus(1'b1, OFF_BDUR, 16'(DUR));
    seed = lfsr(seed);
    duties.push_back(12 + 2 * int'(seed[7:0] % 9));
    foreach (duties[i]) begin
      bus(1'b1, OFF_PDUTY, 16'(duties[i]));
      meas(P1);
      chk(nh, eff(duties[i]));
      chk(nl, LO);
    end
    bus(1'b1, OFF_PDUTY, 16'(HI));
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, OFF_MODE, 16'(m));
      meas(2 * P1);
      chk(nh, m == 3 ? HI : 2 * HI);
      chk(nl, m == 1 ? 2 * (P1 - HI) : (m == 2 ? 2 * HI : HI));
    end
    bus(1'b1, OFF_MODE, 16'h0000);
    overload <= '1;
    foreach (ctrls[i]) begin
      bus(1'b1, OFF_BCTRL, ctrls[i]);
      bus(1'b1, OFF_AUX, {12'h000, auxs[i]});
      meas(P1);
      chk(nf, blank_cnt(ctrls[i], blank_signal_in[auxs[i]], ctrls[i][11]));
      chk(nc, blank_cnt(ctrls[i], blank_signal_in[auxs[i]], ctrls[i][10]));
    end
    bus(1'b1, OFF_BCTRL, 16'h0000);
    overload <= '0;
    meas(P1);
    chk(nf, P1 - HI);
    chk(nc, P1);
    end_sim();
  end
endmodule
